/* hw/dts_pkg.sv */
/*
 Package for the dual target two-wire slave: constants, types, carriers.
 Assumes the user side runs on i_mclk; bus pins on the serial clock domain.
*/
package dts_pkg;

  // ----------------------------------------------------------------
  // Slave address fields
  // ----------------------------------------------------------------
  localparam logic [3:0] DTS_ID_MEM    = 4'hA;
  localparam logic [3:0] DTS_ID_CLK    = 4'hD;
  localparam int         DTS_ID_MSB    = 7;
  localparam int         DTS_ID_LSB    = 4;
  localparam int         DTS_SEL_MSB   = 3;
  localparam int         DTS_SEL_LSB   = 1;
  localparam int         DTS_DIR_BIT   = 0;

  // ----------------------------------------------------------------
  // Address latches and bit counter marks
  // ----------------------------------------------------------------
  localparam int          DTS_MEM_AW    = 15;
  localparam int          DTS_CLK_AW    = 4;
  localparam logic [14:0] DTS_MEM_RST   = 15'h0000;
  localparam logic [3:0]  DTS_CLK_RST   = 4'h0;
  localparam logic [3:0]  DTS_BIT_LAST  = 4'h7;
  localparam logic [3:0]  DTS_BIT_ACK   = 4'h8;

  typedef enum logic [2:0] {
    DTS_IDLE  = 3'b000,
    DTS_SADR  = 3'b001,
    DTS_AHI   = 3'b010,
    DTS_ALO   = 3'b011,
    DTS_WDAT  = 3'b100,
    DTS_RDAT  = 3'b101
  } dts_state_t;

  // Write request from link domain toward user side
  typedef struct packed {
    logic        clk_tgt;
    logic [14:0] addr;
    logic [7:0]  data;
  } dts_wreq_t;

  // Read request: target and address to fetch
  typedef struct packed {
    logic        clk_tgt;
    logic [14:0] addr;
  } dts_rreq_t;

endpackage

/* hw/dts_slave.sv */
/*
 Two-wire slave front end with a memory target and a clock-register target.
 Serial logic runs on the bus clock pin i_scl as its own clock domain;
 byte port runs on i_mclk. Read data must be returned within one and a half
 SCL periods of the fetch edge (i_mclk far faster than SCL). Select pins are static.
*/
`timescale 1ns/100ps

module dts_slave
  import dts_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe,
  input  wire logic [2:0]  i_chip_select_pins,
  output logic             o_wr_stb,
  output logic             o_rd_stb,
  output logic             o_clk_tgt,
  output logic [14:0]      o_addr,
  output logic [7:0]       o_wdata,
  input  wire logic [7:0]  i_rdata
);

  // ----------------------------------------------------------------
  // Start and Stop detection
  // ----------------------------------------------------------------
  // Start toggles on SDA fall while SCL high, Stop on SDA rise.
  logic start_tgl;
  logic stop_tgl;
  logic start_seen;
  logic stop_seen;
  logic start_ack;
  logic stop_ack;

  always_ff @(negedge i_sda or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      start_tgl <= 1'b0;
    end else if (i_scl) begin
      start_tgl <= ~start_tgl;
    end
  end

  always_ff @(posedge i_sda or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stop_tgl <= 1'b0;
    end else if (i_scl) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  assign start_seen = start_tgl ^ start_ack;
  assign stop_seen  = stop_tgl ^ stop_ack;

  // ----------------------------------------------------------------
  // Serial state on SCL rising edge
  // ----------------------------------------------------------------
  dts_state_t  state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic        tgt_clk;
  logic        sel_ok;
  logic        addr_hit;
  logic [14:0] mem_ptr;
  logic [3:0]  clk_ptr;
  logic [6:0]  ahi;
  logic        wr_tgl;
  logic        rd_tgl;
  dts_wreq_t   wreq;
  dts_rreq_t   rreq;
  logic [7:0]  next_byte;
  logic [14:0] cur_addr;

  // ----------------------------------------------------------------
  // Address byte decoding
  // ----------------------------------------------------------------
  function automatic logic id_is_clk(input logic [7:0] b);
    return b[DTS_ID_MSB:DTS_ID_LSB] == DTS_ID_CLK;
  endfunction

  function automatic logic id_is_mem(input logic [7:0] b);
    return b[DTS_ID_MSB:DTS_ID_LSB] == DTS_ID_MEM;
  endfunction

  // Byte port address for the selected target
  function automatic logic [14:0] pick_addr(input logic        clk_sel,
                                            input logic [14:0] mptr,
                                            input logic [3:0]  cptr);
    return clk_sel ? {11'h000, cptr} : mptr;
  endfunction

  assign next_byte = {shreg[6:0], i_sda};
  assign sel_ok = next_byte[DTS_SEL_MSB:DTS_SEL_LSB] ==
                  i_chip_select_pins;
  assign addr_hit = sel_ok &&
                    (id_is_mem(next_byte) || id_is_clk(next_byte));
  assign cur_addr = pick_addr(tgt_clk, mem_ptr, clk_ptr);

  always_ff @(posedge i_scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state     <= DTS_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      tgt_clk   <= 1'b0;
      mem_ptr   <= DTS_MEM_RST;
      clk_ptr   <= DTS_CLK_RST;
      ahi       <= 7'h00;
      wr_tgl    <= 1'b0;
      rd_tgl    <= 1'b0;
      wreq      <= '0;
      rreq      <= '0;
      start_ack <= 1'b0;
      stop_ack  <= 1'b0;
    end else if (start_seen) begin
      // Start aborts anything pending; this edge is first address bit
      start_ack <= start_tgl;
      stop_ack  <= stop_tgl;
      state     <= DTS_SADR;
      bit_cnt   <= 4'h1;
      shreg     <= {7'h00, i_sda};
    end else if (stop_seen || state == DTS_IDLE) begin
      stop_ack <= stop_tgl;
      state    <= DTS_IDLE;
      bit_cnt  <= 4'h0;
    end else if (bit_cnt == DTS_BIT_ACK) begin
      // Ninth clock: ack slot
      bit_cnt <= 4'h0;
      // Master nack ends the read; next byte already fetched
      if (state == DTS_RDAT && i_sda) begin
        state <= DTS_IDLE;
      end
    end else begin
      shreg   <= next_byte;
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt == DTS_BIT_LAST) begin
        case (state)
          DTS_SADR: begin
            if (addr_hit) begin
              tgt_clk <= id_is_clk(next_byte);
              if (next_byte[DTS_DIR_BIT]) begin
                state  <= DTS_RDAT;
                rreq   <= '{clk_tgt: id_is_clk(next_byte),
                            addr: pick_addr(id_is_clk(next_byte),
                                            mem_ptr, clk_ptr)};
                rd_tgl <= ~rd_tgl;
              end else if (id_is_clk(next_byte)) begin
                state <= DTS_ALO;
              end else begin
                state <= DTS_AHI;
              end
            end else begin
              state <= DTS_IDLE;
            end
          end
          DTS_AHI: begin
            ahi   <= next_byte[6:0];
            state <= DTS_ALO;
          end
          DTS_ALO: begin
            if (tgt_clk) begin
              clk_ptr <= next_byte[3:0];
            end else begin
              mem_ptr <= {ahi, next_byte};
            end
            state <= DTS_WDAT;
          end
          DTS_WDAT: begin
            wreq   <= '{clk_tgt: tgt_clk, addr: cur_addr,
                        data: next_byte};
            wr_tgl <= ~wr_tgl;
            if (tgt_clk) begin
              clk_ptr <= clk_ptr + 4'h1;
            end else begin
              mem_ptr <= mem_ptr + 15'h0001;
            end
          end
          DTS_RDAT: begin
            // Fetch the next byte now so it is back before the ack fall
            rreq   <= '{clk_tgt: tgt_clk,
                        addr: pick_addr(tgt_clk, mem_ptr + 15'h0001,
                                        clk_ptr + 4'h1)};
            rd_tgl <= ~rd_tgl;
            if (tgt_clk) begin
              clk_ptr <= clk_ptr + 4'h1;
            end else begin
              mem_ptr <= mem_ptr + 15'h0001;
            end
          end
          default: state <= DTS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Data line driver on SCL falling edge
  // ----------------------------------------------------------------
  logic [7:0] tx_sh;
  logic [7:0] rd_hold;
  logic       drv_ack;
  logic       drv_dat;
  logic       ack_due;

  // ----------------------------------------------------------------
  // Acknowledge decision
  // ----------------------------------------------------------------
  always_comb begin
    ack_due = 1'b0;
    if (bit_cnt == DTS_BIT_ACK && !start_seen && !stop_seen) begin
      case (state)
        DTS_AHI, DTS_ALO, DTS_WDAT: ack_due = 1'b1;
        DTS_RDAT: ack_due = tx_sh == 8'h00 && !drv_dat;
        default:  ack_due = 1'b0;
      endcase
    end
  end

  always_ff @(negedge i_scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      drv_ack <= 1'b0;
    end else begin
      drv_ack <= ack_due;
    end
  end

  always_ff @(negedge i_scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_sh   <= 8'h00;
      drv_dat <= 1'b0;
    end else begin
      if (state == DTS_RDAT && bit_cnt == 4'h0) begin
        tx_sh   <= {rd_hold[6:0], 1'b0};
        drv_dat <= 1'b1;
      end else if (state == DTS_RDAT && bit_cnt != DTS_BIT_ACK &&
                   drv_dat) begin
        tx_sh <= {tx_sh[6:0], 1'b0};
        drv_dat <= 1'b1;
      end else begin
        // Cleared so an aborted read cannot mask the next address ack
        tx_sh   <= 8'h00;
        drv_dat <= 1'b0;
      end
    end
  end

  logic dat_bit;
  always_ff @(negedge i_scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dat_bit <= 1'b1;
    end else if (state == DTS_RDAT && bit_cnt == 4'h0) begin
      dat_bit <= rd_hold[7];
    end else begin
      dat_bit <= tx_sh[7];
    end
  end

  // Open drain: only ever pull low
  assign o_sda    = 1'b0;
  assign o_sda_oe = drv_ack || (drv_dat && !dat_bit);

  // ----------------------------------------------------------------
  // Crossing to the byte port on i_mclk
  // ----------------------------------------------------------------
  // Request words change on the same SCL edge as the toggle and stay stable for a whole byte after it.
  logic [2:0] wr_sync;
  logic [2:0] rd_sync;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_sync <= 3'b000;
      rd_sync <= 3'b000;
    end else begin
      wr_sync <= {wr_sync[1:0], wr_tgl};
      rd_sync <= {rd_sync[1:0], rd_tgl};
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wr_stb  <= 1'b0;
      o_rd_stb  <= 1'b0;
      o_clk_tgt <= 1'b0;
      o_addr    <= 15'h0000;
      o_wdata   <= 8'h00;
    end else begin
      o_wr_stb <= wr_sync[2] ^ wr_sync[1];
      o_rd_stb <= rd_sync[2] ^ rd_sync[1];
      if (wr_sync[2] ^ wr_sync[1]) begin
        o_clk_tgt <= wreq.clk_tgt;
        o_addr    <= wreq.addr;
        o_wdata   <= wreq.data;
      end else if (rd_sync[2] ^ rd_sync[1]) begin
        o_clk_tgt <= rreq.clk_tgt;
        o_addr    <= rreq.addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data return
  // ----------------------------------------------------------------
  logic rd_stb_q;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_stb_q <= 1'b0;
    end else begin
      rd_stb_q <= o_rd_stb;
    end
  end

  // Read data captured the cycle after the read strobe
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_hold <= 8'hFF;
    end else if (rd_stb_q) begin
      rd_hold <= i_rdata;
    end
  end

endmodule

/* sim/dts_slave_props.sv */
/*
 Checker for dts_slave: timing of the byte port and of the data pull.
 Assumes SCL far slower than i_mclk, each SCL phase many i_mclk cycles.
*/
`timescale 1ns/100ps
module dts_slave_props
  import dts_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_sys_rst,
  input wire logic        i_scl,
  input wire logic        o_sda_oe,
  input wire logic        o_wr_stb,
  input wire logic        o_rd_stb,
  input wire logic [14:0] o_addr,
  input wire logic [7:0]  o_wdata
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  chk_stb_excl: assert property (!(o_wr_stb && o_rd_stb))
    else $error("write and read strobes together");
  chk_wr_pulse: assert property (o_wr_stb |=> !o_wr_stb)
    else $error("write strobe longer than one cycle");
  chk_rd_pulse: assert property (o_rd_stb |=> !o_rd_stb)
    else $error("read strobe longer than one cycle");
  chk_addr_hold: assert property ($changed(o_addr) |-> o_wr_stb || o_rd_stb)
    else $error("address moved without a strobe");
  chk_data_hold: assert property ($changed(o_wdata) |-> o_wr_stb)
    else $error("write data moved without a strobe");
  chk_pull_edge: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data pull changed while clock high");
  chk_wr_no_pull: assert property (o_wr_stb |-> !o_sda_oe)
    else $error("data pulled during a received bit");
  chk_wr_ack: assert property (o_wr_stb |-> ##[1:200] o_sda_oe)
    else $error("written byte not acknowledged");
  chk_pull_len: assert property ($rose(o_sda_oe) |-> o_sda_oe[*8])
    else $error("data pull shorter than a bit");
endmodule

bind dts_slave dts_slave_props u_props (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_scl(i_scl),
  .o_sda_oe(o_sda_oe), .o_wr_stb(o_wr_stb), .o_rd_stb(o_rd_stb),
  .o_addr(o_addr), .o_wdata(o_wdata));

/* sim/dts_bus_master.sv */
/*
 Two-wire bus master model: makes SCL and pulls SDA low when asked.
 Assumes SDA has a pull-up; SCL stands high between frames.
*/
`timescale 1ns/100ps
module dts_bus_master #(
  parameter int HALF = 40
) (
  output logic      o_scl,
  output logic      o_sda_low,
  input  wire logic i_sda
);
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end
  // Release data, then fall with clock high
  task automatic start;
    #(HALF / 4) o_sda_low = 1'b0;
    #(HALF / 4) o_scl = 1'b1;
    #(HALF) o_sda_low = 1'b1;
    #(HALF) o_scl = 1'b0;
  endtask
  task automatic stop;
    #(HALF / 4) o_sda_low = 1'b1;
    #(HALF / 4) o_scl = 1'b1;
    #(HALF) o_sda_low = 1'b0;
    #(HALF);
  endtask
  // Data set in low phase, sampled mid high phase
  task automatic bitx(input logic b, output logic r);
    #(HALF / 4) o_sda_low = !b;
    #(HALF * 3 / 4) o_scl = 1'b1;
    #(HALF / 2) r = i_sda;
    #(HALF / 2) o_scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic ackit, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(!ackit, r);
  endtask
endmodule

/* sim/dts_slave_tb.sv */
/*
 Self-checking bench for dts_slave with a bus master model and a byte store.
 Assumes select straps 101 and SCL far slower than i_mclk.
*/
`timescale 1ns/100ps
module dts_slave_tb;
  import dts_pkg::*;
  localparam logic [2:0] SEL = 3'h5;
  logic        i_mclk, i_sys_rst, scl, m_low, o_sda, o_sda_oe, ack;
  logic        o_wr_stb, o_rd_stb, o_clk_tgt;
  logic [14:0] o_addr;
  logic [7:0]  o_wdata, i_rdata, rd;
  logic [23:0] last_w;
  int          fail_count, num_checks, n_wr;
  wire logic   sda = !(m_low || (o_sda_oe && !o_sda));

  dts_slave u_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_scl(scl),
    .i_sda(sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
    .i_chip_select_pins(SEL), .o_wr_stb(o_wr_stb), .o_rd_stb(o_rd_stb),
    .o_clk_tgt(o_clk_tgt), .o_addr(o_addr), .o_wdata(o_wdata),
    .i_rdata(i_rdata));
  dts_bus_master u_mst (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));

  // Byte store contents as a function of target and address
  function automatic logic [7:0] pat(logic t, logic [14:0] a);
    return t ? {4'hC, a[3:0]} : a[7:0] ^ {1'b0, a[14:8]};
  endfunction
  always @(posedge i_mclk) begin
    i_rdata <= o_rd_stb ? pat(o_clk_tgt, o_addr) : ~i_rdata;
    if (o_wr_stb) begin
      last_w <= {o_clk_tgt, o_addr, o_wdata};
      n_wr   <= n_wr + 1;
    end
  end
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic chk_bit(string what, logic exp, logic got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_val(string what, logic [23:0] exp, logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tx(logic [7:0] b, logic e);
    u_mst.wbyte(b, ack);
    chk_bit("ack", e, ack);
  endtask
  task automatic rx(logic a, logic [7:0] e);
    u_mst.rbyte(a, rd);
    chk_val("rdata", {16'h0000, e}, {16'h0000, rd});
  endtask
  task automatic t_mem_write;
    u_mst.start();
    tx(8'hAA, 1'b1);
    tx(8'hFF, 1'b1);
    tx(8'hFF, 1'b1);
    tx(8'h3C, 1'b1);
    chk_val("wr", {1'b0, 15'h7FFF, 8'h3C}, last_w);
    tx(8'hC3, 1'b1);
    chk_val("wrap", {1'b0, 15'h0000, 8'hC3}, last_w);
    u_mst.stop();
    $display("mem write done");
  endtask
  task automatic t_read_seq;
    u_mst.start();
    tx(8'hAB, 1'b1);
    rx(1'b1, pat(1'b0, 15'h0001));
    rx(1'b0, pat(1'b0, 15'h0002));
    chk_bit("released", 1'b0, o_sda_oe);
    u_mst.stop();
    $display("read seq done");
  endtask
  task automatic t_clk_write;
    u_mst.start();
    tx(8'hDA, 1'b1);
    tx(8'hF3, 1'b1);
    tx(8'h11, 1'b1);
    chk_val("cw", {11'h0, 13'h1311}, {11'h0, last_w[23], last_w[11:0]});
    tx(8'h22, 1'b1);
    chk_val("cw2", {11'h0, 13'h1422}, {11'h0, last_w[23], last_w[11:0]});
    u_mst.stop();
    $display("clock write done");
  endtask
  task automatic t_rand_read;
    int n0;
    n0 = n_wr;
    u_mst.start();
    tx(8'hAA, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h40, 1'b1);
    u_mst.start();
    tx(8'hAB, 1'b1);
    rx(1'b0, pat(1'b0, 15'h0040));
    u_mst.start();
    tx(8'hDB, 1'b1);
    rx(1'b0, pat(1'b1, 15'h0005));
    u_mst.start();
    tx(8'hAB, 1'b1);
    rx(1'b0, pat(1'b0, 15'h0041));
    u_mst.stop();
    chk_val("nwr", 24'(n0), 24'(n_wr));
    $display("random read done");
  endtask
  task automatic t_refuse_abort;
    int n0;
    n0 = n_wr;
    u_mst.start();
    tx(8'hA2, 1'b0);
    u_mst.start();
    tx(8'h5A, 1'b0);
    u_mst.start();
    tx(8'hAA, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h10, 1'b1);
    repeat (4) u_mst.bitx(1'b0, ack);
    u_mst.start();
    tx(8'hAB, 1'b1);
    rx(1'b0, pat(1'b0, 15'h0010));
    u_mst.stop();
    chk_val("nwr", 24'(n0), 24'(n_wr));
    $display("refuse abort done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    i_sys_rst  = 1'b1;
    i_rdata    = 8'h00;
    fail_count = 0;
    num_checks = 0;
    n_wr       = 0;
    repeat (2) @(posedge i_mclk);
    #1 i_sys_rst = 1'b0;
    repeat (2) @(posedge i_mclk);
    t_mem_write();
    t_read_seq();
    t_clk_write();
    t_rand_read();
    t_refuse_abort();
    give_verdict();
  end
  initial begin
    #200000;
    fail_count++;
    $display("[ERR] watchdog expected done seen hang");
    give_verdict();
  end
endmodule
